// ---- icc_cfg.svh ----
// offsets, field positions, reset values and timing counts of the serial channel
`ifndef ICC_CFG_SVH
`define ICC_CFG_SVH
`define ICC_ADR_EIE   8'he8
`define ICC_ADR_CON   8'he9
`define ICC_ADR_OWN   8'hea
`define ICC_ADR_TMR   8'hef
`define ICC_EIE_MASK  8'h13
`define ICC_EIE_CH1   0
`define ICC_CON_ENS   6
`define ICC_CON_STA   5
`define ICC_CON_STO   4
`define ICC_CON_SI    3
`define ICC_CON_AA    2
`define ICC_TMR_TIMEOUT_CLOCK_DIVIDE  2
`define ICC_TMR_TIMEOUT_COUNTER_ENABLE  1
`define ICC_TMR_TIF   0
`define ICC_RST_BYTE  8'h00
`define ICC_CLK_MHZ   100
`define ICC_HALF_NS   5000
// least time, so round up to whole cycles
`define ICC_HALF_CYC  ((`ICC_HALF_NS * `ICC_CLK_MHZ + 999) / 1000)
`define ICC_TMO_TICKS 16384
`define ICC_PRE_LAST  2'h3
`define ICC_ST_IDLE   8'hf8
`define ICC_ST_START  8'h08
`define ICC_ST_RSTART 8'h10
`define ICC_ST_OWN    8'h60
`define ICC_ST_GCALL  8'h70
`define ICC_ST_DACK   8'h80
`define ICC_ST_DNACK  8'h88
`define ICC_ST_GACK   8'h90
`define ICC_ST_GNACK  8'h98
`define ICC_ST_STOP   8'ha0
`endif

// ---- icc_pkg.sv ----
// types shared by the serial channel control modules
package icc_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } icc_sfr_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } icc_evt_t;

  typedef enum logic [3:0] {
    E_IDLE, E_MSTART, E_MHOLD, E_MRSUP, E_MRSDN, E_MSTOP,
    E_SADDR, E_SACK, E_SWAIT, E_SDATA, E_SIGN
  } icc_eng_t;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic       scl_p;
    logic       sda_p;
  } icc_sync_st_t;

  typedef struct packed {
    logic [1:0]  pre;
    logic [15:0] cnt;
    logic        ovf;
  } icc_tmo_st_t;

  typedef struct packed {
    logic [7:0]  extended_interrupt_enable;
    logic        ens;
    logic        start_request;
    logic        stop_request;
    logic        si;
    logic        aa;
    logic [7:0]  own;
    logic        timeout_clock_divide;
    logic        timeout_counter_enable;
    logic        timeout_flag;
    icc_eng_t    state;
    logic        master;
    logic        busy;
    logic [15:0] cnt;
    logic [3:0]  bits;
    logic [7:0]  shreg;
    logic        ack;
    logic        gc;
    logic [7:0]  status;
    logic        scl_oe;
    logic        sda_oe;
    logic        pin_lo;
    logic        irq;
    logic [7:0]  rdata;
  } icc_top_st_t;
endpackage

// ---- icc_sync.sv ----
// two-flop synchronisers for the bus pins and start, stop and clock edge detection
`timescale 1ns/10ps
module icc_sync (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic         scl_i,
  input  wire logic         sda_i,
  output icc_pkg::icc_evt_t evt
);
  icc_pkg::icc_sync_st_t st_q, st_d;

  // only the second stage and the held copy feed the edge logic
  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      st_d.scl_s = {st_q.scl_s[0], scl_i};
      st_d.sda_s = {st_q.sda_s[0], sda_i};
      st_d.scl_p = st_q.scl_s[1];
      st_d.sda_p = st_q.sda_s[1];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{scl_s: 2'h3, sda_s: 2'h3, scl_p: 1'b1, sda_p: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  // data moving while the clock stays high marks start or stop
  assign evt.scl      = st_q.scl_s[1];
  assign evt.sda      = st_q.sda_s[1];
  assign evt.scl_rise = st_q.scl_s[1] & ~st_q.scl_p;
  assign evt.scl_fall = ~st_q.scl_s[1] & st_q.scl_p;
  assign evt.start    = st_q.scl_s[1] & st_q.scl_p & st_q.sda_p & ~st_q.sda_s[1];
  assign evt.stop     = st_q.scl_s[1] & st_q.scl_p & ~st_q.sda_p & st_q.sda_s[1];
endmodule // icc_sync

// ---- icc_tmo.sv ----
// bus time-out counter with selectable tick rate
`timescale 1ns/10ps
`include "icc_cfg.svh"
module icc_tmo #(
  parameter int TICKS = `ICC_TMO_TICKS
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic enable,
  input  wire logic timeout_clock_divide,
  output logic      ovf
);
  icc_pkg::icc_tmo_st_t st_q, st_d;
  localparam logic [15:0] LAST = 16'(TICKS - 1);

  // held at zero while off, so turning on always starts from zero
  always_comb begin
    st_d = st_q;
    st_d.ovf = 1'b0;
    if (clk_en) begin
      if (!enable) begin
        st_d.pre = 2'h0;
        st_d.cnt = 16'h0000;
      end else begin
        st_d.pre = st_q.pre + 2'h1;
        if (!timeout_clock_divide || st_q.pre == `ICC_PRE_LAST) begin
          st_d.cnt = (st_q.cnt == LAST) ? 16'h0000 : st_q.cnt + 16'h0001;
          st_d.ovf = (st_q.cnt == LAST);
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign ovf = st_q.ovf;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  tmo_off_a: assert property (clk_en && !enable |=> st_q.cnt == 16'h0000)
    else $error("time-out counter runs while disabled");
  tmo_slow_a: assert property (clk_en && enable && timeout_clock_divide && st_q.pre != `ICC_PRE_LAST
    |=> !st_q.ovf)
    else $error("divided counter ticked off its prescale slot");
  tmo_ovf_c: cover property (st_q.ovf);
endmodule // icc_tmo

// ---- icc_channel.sv ----
// serial channel control: registers, start/stop generation, slave address match
// How it works
// - enable bit turns the channel on
// - start request drives START when bus free
// - master stop request sends STOP, self-clears
// - slave stop request returns to not-addressed
// - new status code other than idle (f8) sets interrupt flag
// - ack enable pulls data low on ack
// - ack disable leaves data high on ack
// - own-address register is read/write, 8 bits
// - master mode ignores own address
// - slave answers only a matching address, or address 00 when own-address bit 0 is set
// - counter overflow sets time-out flag
// - extended enable register gates channel interrupt
`timescale 1ns/10ps
`include "icc_cfg.svh"
module icc_channel #(
  parameter int TMO_TICKS = `ICC_TMO_TICKS
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  icc_pkg::icc_sfr_t sfr,
  output logic [7:0]        sfr_rdata,
  input  wire logic         global_irq_enable,
  output logic              irq,
  output logic [7:0]        channel_status_code,
  input  wire logic         scl_i,
  output logic              scl_o,
  output logic              scl_oe,
  input  wire logic         sda_i,
  output logic              sda_o,
  output logic              sda_oe
);
  localparam logic [15:0] HALF = 16'(`ICC_HALF_CYC);

  icc_pkg::icc_top_st_t st_q, st_d;
  icc_pkg::icc_evt_t    evt;
  logic                 tmo_ovf;
  logic                 own_hit;
  logic                 gc_hit;
  logic                 slave_st;
  logic                 done;

  function automatic logic hit(input icc_pkg::icc_sfr_t r, input logic [7:0] adr);
    hit = r.wr && (r.addr == adr);
  endfunction

  icc_sync u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .evt     (evt)
  );

  icc_tmo #(.TICKS(TMO_TICKS)) u_tmo (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .enable  (st_q.timeout_counter_enable),
    .timeout_clock_divide    (st_q.timeout_clock_divide),
    .ovf     (tmo_ovf)
  );

  // address decisions look at the byte just shifted in
  assign own_hit  = (st_q.shreg[7:1] == st_q.own[7:1]) && !st_q.shreg[0];
  assign gc_hit   = st_q.own[0] && (st_q.shreg == 8'h00);
  assign slave_st = st_q.state inside {icc_pkg::E_SADDR, icc_pkg::E_SACK, icc_pkg::E_SWAIT,
                                       icc_pkg::E_SDATA, icc_pkg::E_SIGN};
  assign done     = (st_q.cnt == 16'h0000);

  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      if (!done) begin
        st_d.cnt = st_q.cnt - 16'h0001;
      end
      if (evt.start) begin
        st_d.busy = 1'b1;
      end
      if (evt.stop) begin
        st_d.busy = 1'b0;
      end

      // protocol engine; a disabled channel lets go of both lines
      if (!st_q.ens) begin
        st_d.state  = icc_pkg::E_IDLE;
        st_d.master = 1'b0;
        st_d.scl_oe = 1'b0;
        st_d.sda_oe = 1'b0;
        st_d.status = `ICC_ST_IDLE;
      end else if (slave_st && st_q.stop_request) begin
        st_d.state  = icc_pkg::E_IDLE;
        st_d.stop_request    = 1'b0;
        st_d.scl_oe = 1'b0;
        st_d.sda_oe = 1'b0;
        st_d.status = `ICC_ST_IDLE;
      end else if (slave_st && evt.stop) begin
        st_d.state  = icc_pkg::E_IDLE;
        st_d.scl_oe = 1'b0;
        st_d.sda_oe = 1'b0;
        st_d.status = (st_q.state == icc_pkg::E_SIGN) ? `ICC_ST_IDLE : `ICC_ST_STOP;
      end else if (slave_st && evt.start) begin
        st_d.state  = icc_pkg::E_SADDR;
        st_d.bits   = 4'h0;
        st_d.scl_oe = 1'b0;
        st_d.sda_oe = 1'b0;
      end else begin
        case (st_q.state)
          icc_pkg::E_IDLE: begin
            if (st_q.start_request && !st_q.busy && !evt.start) begin
              st_d.sda_oe = 1'b1;
              st_d.cnt    = HALF;
              st_d.state  = icc_pkg::E_MSTART;
            end else if (evt.start) begin
              st_d.bits  = 4'h0;
              st_d.state = icc_pkg::E_SADDR;
            end
          end
          icc_pkg::E_MSTART: begin
            if (done) begin
              st_d.scl_oe = 1'b1;
              st_d.master = 1'b1;
              st_d.status = st_q.master ? `ICC_ST_RSTART : `ICC_ST_START;
              st_d.cnt    = HALF;
              st_d.state  = icc_pkg::E_MHOLD;
            end
          end
          icc_pkg::E_MHOLD: begin
            // the bus is held with the clock low until software answers
            if (!st_q.si && done) begin
              if (st_q.stop_request) begin
                st_d.sda_oe = 1'b1;
                st_d.scl_oe = 1'b0;
                st_d.cnt    = HALF;
                st_d.state  = icc_pkg::E_MSTOP;
              end else if (st_q.start_request) begin
                st_d.sda_oe = 1'b0;
                st_d.cnt    = HALF;
                st_d.state  = icc_pkg::E_MRSUP;
              end
            end
          end
          icc_pkg::E_MRSUP: begin
            if (done) begin
              st_d.scl_oe = 1'b0;
              st_d.cnt    = HALF;
              st_d.state  = icc_pkg::E_MRSDN;
            end
          end
          icc_pkg::E_MRSDN: begin
            // wait for a slow slave to release the clock before the edge
            if (done && evt.scl) begin
              st_d.sda_oe = 1'b1;
              st_d.cnt    = HALF;
              st_d.state  = icc_pkg::E_MSTART;
            end
          end
          icc_pkg::E_MSTOP: begin
            if (done && evt.scl) begin
              st_d.sda_oe = 1'b0;
            end
            if (evt.stop) begin
              st_d.stop_request    = 1'b0;
              st_d.master = 1'b0;
              st_d.status = `ICC_ST_IDLE;
              st_d.state  = icc_pkg::E_IDLE;
            end
          end
          icc_pkg::E_SADDR, icc_pkg::E_SDATA: begin
            if (evt.scl_rise) begin
              st_d.shreg = {st_q.shreg[6:0], evt.sda};
              st_d.bits  = st_q.bits + 4'h1;
            end else if (evt.scl_fall && st_q.bits == 4'h8) begin
              st_d.bits  = 4'h0;
              st_d.state = icc_pkg::E_SACK;
              if (st_q.state == icc_pkg::E_SADDR) begin
                st_d.gc     = gc_hit;
                st_d.ack    = 1'b1;
                st_d.sda_oe = 1'b1;
                st_d.status = gc_hit ? `ICC_ST_GCALL : `ICC_ST_OWN;
                if (!(own_hit || gc_hit) || !st_q.aa) begin
                  st_d.ack    = 1'b0;
                  st_d.sda_oe = 1'b0;
                  st_d.status = st_q.status;
                  st_d.state  = icc_pkg::E_SIGN;
                end
              end else begin
                st_d.ack    = st_q.aa;
                st_d.sda_oe = st_q.aa;
                if (st_q.gc) begin
                  st_d.status = st_q.aa ? `ICC_ST_GACK : `ICC_ST_GNACK;
                end else begin
                  st_d.status = st_q.aa ? `ICC_ST_DACK : `ICC_ST_DNACK;
                end
              end
            end
          end
          icc_pkg::E_SACK: begin
            // after an ack the clock is stretched until the flag is served
            if (evt.scl_fall) begin
              st_d.sda_oe = 1'b0;
              st_d.scl_oe = st_q.ack;
              st_d.state  = st_q.ack ? icc_pkg::E_SWAIT : icc_pkg::E_SIGN;
            end
          end
          icc_pkg::E_SWAIT: begin
            if (!st_q.si) begin
              st_d.scl_oe = 1'b0;
              st_d.state  = icc_pkg::E_SDATA;
            end
          end
          icc_pkg::E_SIGN: begin
            st_d.status = st_q.si ? st_q.status : `ICC_ST_IDLE; // last code stands until served
          end
          default: begin
            st_d.state = icc_pkg::E_IDLE;
          end
        endcase
      end

      // register writes come after the engine so a software set beats a self-clear
      if (hit(sfr, `ICC_ADR_EIE)) begin
        st_d.extended_interrupt_enable = sfr.wdata & `ICC_EIE_MASK;
      end
      if (hit(sfr, `ICC_ADR_CON)) begin
        st_d.ens = sfr.wdata[`ICC_CON_ENS];
        st_d.start_request = sfr.wdata[`ICC_CON_STA];
        st_d.stop_request = sfr.wdata[`ICC_CON_STO];
        st_d.aa  = sfr.wdata[`ICC_CON_AA];
        if (!sfr.wdata[`ICC_CON_SI]) begin
          st_d.si = 1'b0;
        end
      end
      if (hit(sfr, `ICC_ADR_OWN)) begin
        st_d.own = sfr.wdata;
      end
      if (hit(sfr, `ICC_ADR_TMR)) begin
        st_d.timeout_clock_divide = sfr.wdata[`ICC_TMR_TIMEOUT_CLOCK_DIVIDE];
        st_d.timeout_counter_enable = sfr.wdata[`ICC_TMR_TIMEOUT_COUNTER_ENABLE];
        if (!sfr.wdata[`ICC_TMR_TIF]) begin
          st_d.timeout_flag = 1'b0;
        end
      end

      // hardware sets win over a clear in the same cycle
      if (st_d.status != st_q.status && st_d.status != `ICC_ST_IDLE) begin
        st_d.si = 1'b1;
      end
      if (tmo_ovf) begin
        st_d.timeout_flag = 1'b1;
      end
      st_d.irq = st_d.extended_interrupt_enable[`ICC_EIE_CH1] &&
                 ((st_d.si && global_irq_enable) || st_d.timeout_flag);

      // read data is latched, so it appears the cycle after the strobe
      if (sfr.rd) begin
        case (sfr.addr)
          `ICC_ADR_EIE: st_d.rdata = st_q.extended_interrupt_enable;
          `ICC_ADR_CON: st_d.rdata = {1'b0, st_q.ens, st_q.start_request, st_q.stop_request, st_q.si, st_q.aa, 2'b00};
          `ICC_ADR_OWN: st_d.rdata = st_q.own;
          `ICC_ADR_TMR: st_d.rdata = {5'h00, st_q.timeout_clock_divide, st_q.timeout_counter_enable, st_q.timeout_flag};
          default:      st_d.rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= '0;
      st_q.own    <= `ICC_RST_BYTE;
      st_q.state  <= icc_pkg::E_IDLE;
      st_q.status <= `ICC_ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata           = st_q.rdata;
  assign irq                 = st_q.irq;
  assign channel_status_code = st_q.status;
  assign scl_o               = st_q.pin_lo;
  assign scl_oe              = st_q.scl_oe;
  assign sda_o               = st_q.pin_lo;
  assign sda_oe              = st_q.sda_oe;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  ens_off_a: assert property (clk_en && !st_q.ens |=> !st_q.scl_oe && !st_q.sda_oe)
    else $error("disabled channel still drives the bus");
  start_drv_a: assert property (clk_en && st_q.state == icc_pkg::E_IDLE &&
    st_q.ens && st_q.start_request && !st_q.busy && !evt.start |=> st_q.sda_oe ##0
    st_q.state == icc_pkg::E_MSTART) else $error("start request did not pull data low");
  sto_clear_a: assert property (clk_en && st_q.ens &&
    st_q.state == icc_pkg::E_MSTOP && evt.stop && !hit(sfr, `ICC_ADR_CON) |=>
    !st_q.stop_request && !st_q.master) else $error("stop request not cleared after stop");
  slave_sto_a: assert property (clk_en && st_q.ens && slave_st && st_q.stop_request
    |=> st_q.state == icc_pkg::E_IDLE && !st_q.scl_oe && !st_q.sda_oe)
    else $error("slave stop request did not return to idle");
  si_set_a: assert property ($changed(st_q.status) && st_q.status != `ICC_ST_IDLE
    |-> st_q.si) else $error("new status code without interrupt flag");
  irq_gate_a: assert property (st_q.irq |-> st_q.extended_interrupt_enable[`ICC_EIE_CH1] &&
    (st_q.si || st_q.timeout_flag)) else $error("interrupt raised without enable or cause");
  ack_low_a: assert property (st_q.state == icc_pkg::E_SACK && st_q.ack |->
    st_q.sda_oe) else $error("ack enabled but data line released");
  nack_high_a: assert property (st_q.state == icc_pkg::E_SACK && !st_q.ack |->
    !st_q.sda_oe) else $error("not-acknowledge still drives data low");
  master_own_a: assert property (st_q.master |-> !slave_st)
    else $error("own address matched while master");
  tif_set_a: assert property (clk_en && tmo_ovf |=> st_q.timeout_flag)
    else $error("overflow did not set the time-out flag");
  stretch_a: assert property (st_q.state == icc_pkg::E_SWAIT && st_q.si |->
    st_q.scl_oe) else $error("clock released while flag pending");

  mstart_c: cover property (st_q.status == `ICC_ST_START ##[1:1000] st_q.state == icc_pkg::E_MSTOP);
  own_c: cover property (st_q.status == `ICC_ST_OWN);
  gcall_c: cover property (st_q.status == `ICC_ST_GCALL);
  tif_c: cover property (st_q.timeout_flag && st_q.irq);
endmodule // icc_channel

// ---- icc_bus_peer.sv ----
// other master on the two-wire bus: makes frames, sends bytes, reads the acknowledge
`timescale 1ns/10ps
module icc_bus_peer (
  input  wire logic clk_sys,
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  localparam int HALF = 8; // half of the 160 ns link clock
  // link clock stands high outside frames
  logic scl_lo = 1'b0;
  logic sda_lo = 1'b0;

  // open drain with pull-ups: a released line reads high
  assign scl = ~(scl_oe | scl_lo);
  assign sda = ~(sda_oe | sda_lo);

  task automatic half();
    repeat (HALF) @(posedge clk_sys);
  endtask

  // release the clock, wait out any stretch by the device
  task automatic scl_up();
    int n;
    n = 0;
    scl_lo <= 1'b0;
    @(posedge clk_sys);
    while (!scl && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 5000) begin
      tb_top.fails++;
    end
    half();
  endtask

  task automatic start();
    sda_lo <= 1'b1;
    half();
    scl_lo <= 1'b1;
    half();
  endtask

  // msb first, data changed only while the clock is low
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_lo <= ~b[i];
      half();
      scl_up();
      scl_lo <= 1'b1;
    end
    sda_lo <= 1'b0;
    half();
    scl_up();
    ack = ~sda;
    scl_lo <= 1'b1;
    half();
  endtask

  task automatic stop();
    sda_lo <= 1'b1;
    half();
    scl_up();
    sda_lo <= 1'b0;
    half();
  endtask
endmodule // icc_bus_peer

// ---- tb_top.sv ----
// testbench of the serial channel: registers, time-out, slave, master
`timescale 1ns/10ps
module tb_top;
  logic              clk_sys;
  logic              rst_n;
  icc_pkg::icc_sfr_t sfr;
  logic [7:0]        sfr_rdata;
  logic              global_irq_enable;
  logic              irq;
  logic [7:0]        channel_status_code;
  logic              scl;
  logic              sda;
  logic              scl_oe;
  logic              sda_oe;
  logic              scl_o;
  logic              sda_o;
  logic [7:0]        v;
  logic              ack;
  int                fails;
  int                n_checks;
  int                cyc;

  icc_channel #(.TMO_TICKS(8)) u_icc_channel (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .global_irq_enable(global_irq_enable), .irq(irq),
    .channel_status_code(channel_status_code), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));

  icc_bus_peer u_icc_bus_peer (
    .clk_sys(clk_sys), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // hang guard, well above the few thousand cycles the tests need
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk_sys);
    sfr <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    sfr <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk_sys);
    sfr <= '0;
    #1 d = sfr_rdata;
  endtask

  task automatic wait_st(input logic [7:0] exp);
    int n;
    n = 0;
    while (channel_status_code !== exp && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(channel_status_code, exp);
  endtask

  // one addressing frame: start, byte, then the acknowledge seen
  task automatic frame(input logic [7:0] b, input logic exp_ack);
    u_icc_bus_peer.start();
    u_icc_bus_peer.send_byte(b, ack);
    chk({7'h00, ack}, {7'h00, exp_ack});
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    sfr = '0;
    global_irq_enable = 1'b0;
    rst_n = 1'b0;
    cyc = 0;
    fails = 0;
    n_checks = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    // reset values, masks, unmapped place
    for (int i = 0; i < 8; i++) begin
      rd(8'he8 + 8'(i), v);
      chk(v, 8'h00);
    end
    rd(8'he9, v);
    chk(v, 8'h00);
    wr(8'he8, 8'hff);
    rd(8'he8, v);
    chk(v, 8'h13);
    wr(8'hea, 8'ha5);
    rd(8'hea, v);
    chk(v, 8'ha5);
    wr(8'he0, 8'h5a);
    rd(8'he0, v);
    chk(v, 8'h00);
    wr(8'he8, 8'h01);
    $display("test registers done");
    // time-out at both tick rates; flag raises the request without the global gate
    wr(8'hef, 8'h02);
    repeat (12) @(posedge clk_sys);
    rd(8'hef, v);
    chk(v, 8'h03);
    chk({7'h00, irq}, 8'h01);
    wr(8'hef, 8'h00);
    // an overflow already in flight sets the flag again the cycle after the clear
    wr(8'hef, 8'h00);
    rd(8'hef, v);
    chk(v, 8'h00);
    wr(8'hef, 8'h01);
    rd(8'hef, v);
    chk(v, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(8'hef, 8'h06);
    repeat (18) @(posedge clk_sys);
    rd(8'hef, v);
    chk(v, 8'h06);
    repeat (22) @(posedge clk_sys);
    rd(8'hef, v);
    chk(v, 8'h07);
    wr(8'hef, 8'h00);
    $display("test timeout done");
    // slave: address, acked data, nacked data; bit 0 always written zero
    global_irq_enable <= 1'b1;
    wr(8'hea, 8'h54);
    wr(8'he9, 8'h44);
    frame(8'h54, 1'b1);
    chk(channel_status_code, 8'h60);
    rd(8'he9, v);
    chk(v, 8'h4c);
    chk({7'h00, irq}, 8'h01);
    @(posedge clk_sys);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({7'h00, irq}, 8'h00);
    global_irq_enable <= 1'b1;
    wr(8'he9, 8'h44);
    u_icc_bus_peer.send_byte(8'h3c, ack);
    chk({7'h00, ack}, 8'h01);
    chk(channel_status_code, 8'h80);
    wr(8'he9, 8'h40);
    u_icc_bus_peer.send_byte(8'h0f, ack);
    chk({7'h00, ack}, 8'h00);
    chk(channel_status_code, 8'h88);
    wr(8'he9, 8'h44);
    u_icc_bus_peer.stop();
    // other address, then a disabled channel
    frame(8'h56, 1'b0);
    rd(8'he9, v);
    chk(v, 8'h44);
    u_icc_bus_peer.stop();
    wr(8'he9, 8'h04);
    frame(8'h54, 1'b0);
    u_icc_bus_peer.stop();
    $display("test slave done");
    // general call, then a stop request in slave mode leaves it unaddressed
    wr(8'hea, 8'h55);
    wr(8'he9, 8'h44);
    frame(8'h00, 1'b1);
    chk(channel_status_code, 8'h70);
    wr(8'he9, 8'h54);
    u_icc_bus_peer.send_byte(8'h3c, ack);
    chk({7'h00, ack}, 8'h00);
    rd(8'he9, v);
    chk(v & 8'h10, 8'h00);
    u_icc_bus_peer.stop();
    $display("test general call done");
    // master start, repeated start, then stop, stop request cleared and both lines released
    wr(8'he9, 8'h64);
    wait_st(8'h08);
    chk({6'h00, scl, sda}, 8'h00);
    chk({6'h00, scl_o, sda_o}, 8'h00);
    wr(8'he9, 8'h64);
    wait_st(8'h10);
    wr(8'he9, 8'h54);
    wait_st(8'hf8);
    rd(8'he9, v);
    chk(v & 8'h10, 8'h00);
    chk({6'h00, scl, sda}, 8'h03);
    $display("test master done");
    results();
  end
endmodule // tb_top
